// file: rtl/tsg_defs.vh
/*
 Constants of the trigger source generator: register offsets, field
 positions, reset values, source codes and the fixed figures of the block.
 Assumes it is included by its bare name from the rtl files.
*/
`ifndef TSG_DEFS_VH
`define TSG_DEFS_VH

// Register offsets (word addresses on the plain register port)
`define TSG_ADDR_CTRL 4'h0
`define TSG_ADDR_ADC_LEVEL 4'h1
`define TSG_ADDR_MAG_LEVEL 4'h2
`define TSG_ADDR_DWELL 4'h3
`define TSG_ADDR_STATUS 4'h4
`define TSG_ADDR_THRESH 4'h5
`define TSG_ADDR_HWINFO 4'h6

// Control register fields
`define TSG_CTRL_SRC_LSB 0
`define TSG_CTRL_SRC_MSB 2
`define TSG_CTRL_SLOPE_BIT 4
`define TSG_CTRL_GEN_BIT 5
`define TSG_CTRL_RESET 32'h0000_0020

// Status register fields
`define TSG_STAT_FIRED_BIT 0
`define TSG_STAT_ERR_BIT 1
`define TSG_STAT_ARMED_BIT 2
`define TSG_STAT_LOWSEEN_BIT 3

// Trigger source codes
`define TSG_SRC_SOFTWARE_ONLY 3'h0
`define TSG_SRC_RAW_SAMPLE 3'h1
`define TSG_SRC_FRONT_ECL 3'h2
`define TSG_SRC_LEGACY_FRONT 3'h2
`define TSG_SRC_LOG_ENVELOPE 3'h3
`define TSG_SRC_INSTANT 3'h4
`define TSG_SRC_FRONT_TTL 3'h5

// Slope codes
`define TSG_RISING_EDGE_CHOICE 1'b0
`define TSG_FALLING_EDGE_CHOICE 1'b1

// Raw sample threshold settings
`define TSG_ADC_LEVEL_RESET 12'h000
`define TSG_ADC_HYST 13'h0014

// Envelope threshold: level limits, default and step (dB step * 2^16)
`define TSG_MAG_LEVEL_MIN (-337)
`define TSG_MAG_LEVEL_MAX 40
`define TSG_MAG_LEVEL_RESET 10'h380
`define TSG_DB_STEP_Q16 32'h0000_6054

// Dwell count default
`define TSG_DWELL_RESET 24'h000001

`endif

// file: rtl/tsg_log2.v
/*
 Log magnitude estimator for the envelope source: a registered base-2
 logarithm of a 24-bit magnitude in 5.8 fixed point (integer part from the
 leading one, fraction from the next eight bits). Assumes a clocked
 magnitude input on the same clock; one cycle of latency.
*/
`timescale 1ns/1ps
module tsg_log2 (
	// Clock and reset
	input wire i_clk,
	input wire i_rst,
	// Magnitude in, log out
	input wire [23:0] i_mag,
	output reg [12:0] o_log
);
	reg [4:0] lead;
	reg [23:0] norm;
	integer k;

	always @* begin
		lead = 5'h00;
		for (k = 0; k < 24; k = k + 1) begin
			if (i_mag[k])
				lead = k[4:0];
		end
		norm = i_mag << (5'd23 - lead);
	end

	always @(posedge i_clk) begin
		if (i_rst)
			o_log <= 13'h0000;
		else
			o_log <= {lead, norm[22:15]};
	end
endmodule

// file: rtl/tsg_top.v
/*
 Trigger source generator of a single-channel digitizer: selects a raw
 sample, log envelope, front-panel (ECL or TTL), software-only or instant
 trigger source, applies slope and thresholds and drives the shared
 open-collector sync line. Assumes the sync line and front inputs are
 asynchronous, samples and band-limited magnitude arrive on i_clk, and the
 measurement sequencer signals the trigger state as a same-clock level.
*/
`timescale 1ns/1ps
`include "tsg_defs.vh"
module tsg_top #(
	parameter HAS_TTL = 1
) (
	// Clock and reset
	input wire i_clk,
	input wire i_rst,
	// Register port
	input wire [3:0] i_addr,
	input wire [31:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [31:0] o_rdata,
	// Signal inputs
	input wire [11:0] i_sample,
	input wire [23:0] i_band_mag,
	input wire i_front_ecl,
	input wire i_front_ttl,
	// Measurement sequencer
	input wire i_trig_state,
	output reg o_measure_start,
	// Shared open-collector sync line
	input wire i_sync_in,
	output reg o_sync_out,
	output reg o_sync_oe
);
	localparam ST_IDLE = 2'b00;
	localparam ST_ARMED = 2'b01;
	localparam ST_FIRED = 2'b10;
	localparam signed [9:0] LVL_MIN = `TSG_MAG_LEVEL_MIN;
	localparam signed [9:0] LVL_MAX = `TSG_MAG_LEVEL_MAX;

	reg [31:0] ctrl_reg;
	reg [11:0] adc_level_reg;
	reg [9:0] mag_level_reg;
	reg [23:0] dwell_reg;
	reg [1:0] state_reg, state_next;
	reg [1:0] ecl_sync_reg, ttl_sync_reg, line_sync_reg;
	reg ecl_prev_reg, ttl_prev_reg;
	reg adc_above_reg;
	reg [23:0] low_cnt_reg;
	reg low_seen_reg;
	reg err_reg;
	reg [12:0] thresh_reg;
	reg [9:0] level_clamped;
	reg [31:0] db_prod;
	reg fire;
	reg ev;
	wire [12:0] log_mag;
	wire signed [31:0] th_scaled;
	wire [2:0] src;
	wire slope;
	wire line_low;
	wire [12:0] samp_s;
	wire [12:0] lvl_s;
	wire ecl_rise, ecl_fall, ttl_rise, ttl_fall;
	wire adc_rise, adc_fall;
	wire mag_low, mag_above;

	assign src = ctrl_reg[`TSG_CTRL_SRC_MSB:`TSG_CTRL_SRC_LSB];
	assign slope = ctrl_reg[`TSG_CTRL_SLOPE_BIT];
	assign line_low = line_sync_reg[1];

	tsg_log2 u_log (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_mag(i_band_mag),
		.o_log(log_mag)
	);

	// Register writes
	always @(posedge i_clk) begin
		if (i_rst) begin
			ctrl_reg <= `TSG_CTRL_RESET;
			adc_level_reg <= `TSG_ADC_LEVEL_RESET;
			mag_level_reg <= `TSG_MAG_LEVEL_RESET;
			dwell_reg <= `TSG_DWELL_RESET;
		end else if (i_wr) begin
			if (i_addr == `TSG_ADDR_CTRL) begin
				ctrl_reg <= {26'h0, i_wdata[5:0]};
			end else if (i_addr == `TSG_ADDR_ADC_LEVEL) begin
				adc_level_reg <= i_wdata[11:0];
			end else if (i_addr == `TSG_ADDR_MAG_LEVEL) begin
				mag_level_reg <= i_wdata[9:0];
			end else if (i_addr == `TSG_ADDR_DWELL) begin
				dwell_reg <= i_wdata[23:0];
			end
		end
	end

	always @* begin
		if ($signed(mag_level_reg) < LVL_MIN)
			level_clamped = LVL_MIN;
		else if ($signed(mag_level_reg) > LVL_MAX)
			level_clamped = LVL_MAX;
		else
			level_clamped = mag_level_reg;
		db_prod = $signed({{22{level_clamped[9]}}, level_clamped}) * $signed(`TSG_DB_STEP_Q16);
	end

	// dB to log2 threshold
	// Full scale sits at log2 = 23; a dB step of 6.02 is one octave, so dB*2^8/6.02 in 5.8.
	assign th_scaled = ($signed(db_prod) * 32'sd43) >>> 16;
	always @(posedge i_clk) begin
		if (i_rst)
			thresh_reg <= 13'h0000;
		else
			thresh_reg <= 13'h1700 + th_scaled[12:0];
	end

	// Two-flop synchronisers for pins
	always @(posedge i_clk) begin
		if (i_rst) begin
			ecl_sync_reg <= 2'b00;
			ttl_sync_reg <= 2'b00;
			line_sync_reg <= 2'b00;
			ecl_prev_reg <= 1'b0;
			ttl_prev_reg <= 1'b0;
		end else begin
			ecl_sync_reg <= {ecl_sync_reg[0], i_front_ecl};
			ttl_sync_reg <= {ttl_sync_reg[0], i_front_ttl};
			line_sync_reg <= {line_sync_reg[0], i_sync_in};
			ecl_prev_reg <= ecl_sync_reg[1];
			ttl_prev_reg <= ttl_sync_reg[1];
		end
	end

	assign ecl_rise = ecl_sync_reg[1] & ~ecl_prev_reg;
	assign ecl_fall = ~ecl_sync_reg[1] & ecl_prev_reg;
	assign ttl_rise = ttl_sync_reg[1] & ~ttl_prev_reg;
	assign ttl_fall = ~ttl_sync_reg[1] & ttl_prev_reg;

	assign samp_s = {i_sample[11], i_sample};
	assign lvl_s = {adc_level_reg[11], adc_level_reg};
	always @(posedge i_clk) begin
		if (i_rst)
			adc_above_reg <= 1'b0;
		else if ($signed(samp_s) >= $signed(lvl_s + `TSG_ADC_HYST))
			adc_above_reg <= 1'b1;
		else if ($signed(samp_s) <= $signed(lvl_s - `TSG_ADC_HYST))
			adc_above_reg <= 1'b0;
	end
	assign adc_rise = ~adc_above_reg & ($signed(samp_s) >= $signed(lvl_s + `TSG_ADC_HYST));
	assign adc_fall = adc_above_reg & ($signed(samp_s) <= $signed(lvl_s - `TSG_ADC_HYST));

	assign mag_low = log_mag < thresh_reg;
	assign mag_above = ~mag_low;
	always @(posedge i_clk) begin
		if (i_rst || state_reg != ST_ARMED) begin
			low_cnt_reg <= 24'h000000;
			low_seen_reg <= 1'b0;
		end else if (mag_low) begin
			if (low_cnt_reg < dwell_reg)
				low_cnt_reg <= low_cnt_reg + 24'h000001;
			else
				low_seen_reg <= 1'b1;
		end else begin
			low_cnt_reg <= 24'h000000;
		end
	end

	// Event selection per source
	always @* begin
		case (src)
			`TSG_SRC_RAW_SAMPLE: ev = (slope == `TSG_FALLING_EDGE_CHOICE) ? adc_fall : adc_rise;
			`TSG_SRC_FRONT_ECL: ev = (slope == `TSG_FALLING_EDGE_CHOICE) ? ecl_fall : ecl_rise;
			`TSG_SRC_FRONT_TTL: ev = (HAS_TTL != 0) &&
				((slope == `TSG_FALLING_EDGE_CHOICE) ? ttl_fall : ttl_rise);
			`TSG_SRC_LOG_ENVELOPE: ev = low_seen_reg & mag_above;
			`TSG_SRC_INSTANT: ev = 1'b1;
			default: ev = 1'b0;
		endcase
	end

	// gate on state and released line
	always @* begin
		fire = (state_reg == ST_ARMED) && i_trig_state && ev && ~line_low &&
			ctrl_reg[`TSG_CTRL_GEN_BIT];
	end

	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: if (i_trig_state) state_next = ST_ARMED;
			ST_ARMED: begin
				if (!i_trig_state)
					state_next = ST_IDLE;
				else if (fire || line_low)
					state_next = ST_FIRED;
			end
			ST_FIRED: if (!i_trig_state) state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	// instant fires on entry
	// Instant skips the arm cycle so it fires in the first trigger-state cycle.
	wire instant_now;
	assign instant_now = (state_reg == ST_IDLE) && i_trig_state && (src == `TSG_SRC_INSTANT) &&
		~line_low && ctrl_reg[`TSG_CTRL_GEN_BIT];

	always @(posedge i_clk) begin
		if (i_rst) begin
			state_reg <= ST_IDLE;
			o_sync_out <= 1'b0;
			o_sync_oe <= 1'b0;
			o_measure_start <= 1'b0;
		end else begin
			state_reg <= instant_now ? ST_FIRED : state_next;
			o_sync_oe <= fire | instant_now | (o_sync_oe & i_trig_state);
			o_sync_out <= 1'b0;
			o_measure_start <= fire | instant_now |
				((state_reg == ST_ARMED) & i_trig_state & line_low);
		end
	end

	always @(posedge i_clk) begin
		if (i_rst)
			err_reg <= 1'b0;
		else if (i_wr && i_addr == `TSG_ADDR_CTRL)
			err_reg <= (HAS_TTL == 0) && (i_wdata[2:0] == `TSG_SRC_FRONT_TTL);
	end

	// Register reads, data in the cycle after the strobe
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_rdata <= 32'h0000_0000;
		end else if (i_rd) begin
			if (i_addr == `TSG_ADDR_CTRL)
				o_rdata <= ctrl_reg;
			else if (i_addr == `TSG_ADDR_ADC_LEVEL)
				o_rdata <= {20'h00000, adc_level_reg};
			else if (i_addr == `TSG_ADDR_MAG_LEVEL)
				o_rdata <= {22'h000000, mag_level_reg};
			else if (i_addr == `TSG_ADDR_DWELL)
				o_rdata <= {8'h00, dwell_reg};
			else if (i_addr == `TSG_ADDR_STATUS)
				o_rdata <= {28'h0000000, low_seen_reg, state_reg == ST_ARMED, err_reg,
					state_reg == ST_FIRED};
			else if (i_addr == `TSG_ADDR_THRESH)
				o_rdata <= {19'h00000, thresh_reg};
			else if (i_addr == `TSG_ADDR_HWINFO)
				o_rdata <= {31'h00000000, HAS_TTL != 0};
			else
				o_rdata <= 32'h0000_0000;
		end else begin
			o_rdata <= 32'h0000_0000;
		end
	end
endmodule

// file: verification/tsg_props.sv
/* Port checker for the trigger source generator, bound to tsg_top.
 Assumes the sync line level is fed back to i_sync_in, high when pulled. */
`timescale 1ns/1ps
`include "tsg_defs.vh"
module tsg_props (
	// Clock and reset
	input wire i_clk,
	input wire i_rst,
	// Register writes
	input wire [3:0] i_addr,
	input wire [31:0] i_wdata,
	input wire i_wr,
	// Trigger side
	input wire i_trig_state,
	input wire o_measure_start,
	input wire i_sync_in,
	input wire o_sync_out,
	input wire o_sync_oe
);
	reg [2:0] src_reg;
	reg gen_reg;
	// Shadow of the source select, so properties know the mode
	always @(posedge i_clk) begin
		if (i_rst) begin
			src_reg <= `TSG_SRC_SOFTWARE_ONLY;
			gen_reg <= 1'b1;
		end else if (i_wr && i_addr == `TSG_ADDR_CTRL) begin
			src_reg <= i_wdata[2:0];
			gen_reg <= i_wdata[5];
		end
	end
	chk_instant_fires: assert property (@(posedge i_clk) disable iff (i_rst)
		(src_reg == `TSG_SRC_INSTANT && gen_reg && $rose(i_trig_state) && !i_sync_in
		&& $past(!i_sync_in) && $past(!i_sync_in, 2)) |=> o_measure_start)
		else $error("instant source did not start the measurement");
	chk_start_one_cycle: assert property (@(posedge i_clk) disable iff (i_rst)
		o_measure_start |=> !o_measure_start)
		else $error("measurement start longer than one cycle");
	chk_no_retrigger: assert property (@(posedge i_clk) disable iff (i_rst)
		o_measure_start && i_trig_state ##1 i_trig_state [*3] |-> !o_measure_start)
		else $error("second trigger within one trigger state");
	chk_start_in_state: assert property (@(posedge i_clk) disable iff (i_rst)
		o_measure_start |-> $past(i_trig_state))
		else $error("measurement start outside the trigger state");
	chk_pull_with_start: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(o_sync_oe) |-> o_measure_start && $past(i_trig_state))
		else $error("sync pulled without a trigger");
	chk_pull_holds: assert property (@(posedge i_clk) disable iff (i_rst)
		o_sync_oe && i_trig_state |=> o_sync_oe)
		else $error("sync released inside the trigger state");
	chk_pull_drops: assert property (@(posedge i_clk) disable iff (i_rst)
		!i_trig_state |=> !o_sync_oe)
		else $error("sync still pulled after the trigger state");
	chk_open_collector: assert property (@(posedge i_clk) disable iff (i_rst)
		o_sync_out == 1'b0)
		else $error("sync data driven high");
	chk_user_no_pull: assert property (@(posedge i_clk) disable iff (i_rst)
		src_reg == `TSG_SRC_SOFTWARE_ONLY && $past(src_reg) == `TSG_SRC_SOFTWARE_ONLY
		|-> !$rose(o_sync_oe))
		else $error("software-only source pulled the sync line");
endmodule
bind tsg_top tsg_props u_props (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_trig_state(i_trig_state),
	.o_measure_start(o_measure_start), .i_sync_in(i_sync_in), .o_sync_out(o_sync_out),
	.o_sync_oe(o_sync_oe));

// file: verification/tsg_peer.sv
/* Model of a cooperating digitizer sharing the sync line.
 Assumes the line level is the OR of all pulls, high meaning pulled. */
`timescale 1ns/1ps
module tsg_peer (
	// Clock
	input wire i_clk,
	// Bench command and line level
	input wire i_pull,
	input wire i_line,
	// Pull enable on the shared line
	output logic o_pull_oe = 1'b0
);
	// pulls only a released line, same source type assumed
	always @(posedge i_clk) begin
		o_pull_oe <= i_pull && (o_pull_oe || !i_line);
	end
endmodule

// file: verification/tb_top.sv
/* Self-checking bench of the trigger source generator.
 Assumes tsg_top, tsg_peer and the bound checker are compiled before it. */
`timescale 1ns/1ps
`include "tsg_defs.vh"
module tb_top;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [3:0] i_addr = 4'h0;
	logic [31:0] i_wdata = 32'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [11:0] i_sample = 12'h000;
	logic [23:0] i_band_mag = 24'hFFFFFF;
	logic i_front_ecl = 1'b0;
	logic i_front_ttl = 1'b0;
	logic i_trig_state = 1'b0;
	logic peer_pull = 1'b0;
	wire [31:0] o_rdata;
	wire o_measure_start, o_sync_out, o_sync_oe, peer_oe;
	wire sync_line = o_sync_oe | peer_oe;
	int n_mismatch = 0;
	int check_count = 0;
	int lvl;
	int sgn;
	logic [31:0] t_ref;
	always #10 i_clk = ~i_clk;
	tsg_top #(.HAS_TTL(1)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sample(i_sample),
		.i_band_mag(i_band_mag), .i_front_ecl(i_front_ecl), .i_front_ttl(i_front_ttl),
		.i_trig_state(i_trig_state), .o_measure_start(o_measure_start),
		.i_sync_in(sync_line), .o_sync_out(o_sync_out), .o_sync_oe(o_sync_oe));
	tsg_peer peer (.i_clk(i_clk), .i_pull(peer_pull), .i_line(sync_line), .o_pull_oe(peer_oe));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m,
		input string what);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 chk(what, exp & m, o_rdata & m);
	endtask
	task automatic rd_val(input logic [3:0] a, output logic [31:0] v);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 v = o_rdata;
	endtask
	// Bounded watch for a start pulse; a seen or missing pulse that differs from exp counts as a mismatch
	task automatic expect_start(input logic exp, input int n, input string what);
		logic seen;
		seen = 1'b0;
		repeat (n) begin
			@(posedge i_clk);
			#1 if (o_measure_start === 1'b1) seen = 1'b1;
		end
		chk(what, {31'h0, exp}, {31'h0, seen});
	endtask
	task automatic enter_state;
		@(posedge i_clk) i_trig_state <= 1'b1;
	endtask
	task automatic leave_state;
		@(posedge i_clk) i_trig_state <= 1'b0;
		repeat (3) @(posedge i_clk);
	endtask
	task finish_test;
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge i_clk);
		n_mismatch++;
		finish_test;
	end
	initial begin
		void'($urandom(76));
		repeat (4) @(posedge i_clk);
		i_rst <= 1'b0;
		rd_chk(`TSG_ADDR_CTRL, `TSG_CTRL_RESET, 32'h3F, "ctrl");
		rd_chk(`TSG_ADDR_MAG_LEVEL, 32'h380, 32'h3FF, "mag_reset");
		rd_chk(`TSG_ADDR_DWELL, 32'h1, 32'hFFFFFF, "dwell_reset");
		rd_chk(`TSG_ADDR_HWINFO, 32'h1, 32'h1, "ttl_present");
		rd_chk(4'h7, 32'h0, 32'hFFFFFFFF, "unmapped");
		wr(`TSG_ADDR_MAG_LEVEL, 32'h028);
		rd_val(`TSG_ADDR_THRESH, t_ref);
		wr(`TSG_ADDR_MAG_LEVEL, 32'h029);
		rd_chk(`TSG_ADDR_MAG_LEVEL, 32'h029, 32'h3FF, "mag_raw_top");
		rd_chk(`TSG_ADDR_THRESH, t_ref, 32'h1FFF, "mag_top");
		wr(`TSG_ADDR_MAG_LEVEL, 32'h2AF);
		rd_val(`TSG_ADDR_THRESH, t_ref);
		wr(`TSG_ADDR_MAG_LEVEL, 32'h2AE);
		rd_chk(`TSG_ADDR_MAG_LEVEL, 32'h2AE, 32'h3FF, "mag_raw_bottom");
		rd_chk(`TSG_ADDR_THRESH, t_ref, 32'h1FFF, "mag_bottom");
		wr(`TSG_ADDR_MAG_LEVEL, 32'h380);
		wr(`TSG_ADDR_CTRL, 32'h04);
		enter_state;
		expect_start(1'b0, 6, "gen_off");
		leave_state;
		wr(`TSG_ADDR_CTRL, 32'h24);
		enter_state;
		expect_start(1'b1, 2, "instant");
		chk("instant_pull", 32'h1, {31'h0, o_sync_oe});
		leave_state;
		for (int s = 0; s < 2; s++) begin
			lvl = int'($urandom_range(1000)) - 500;
			sgn = s ? -1 : 1;
			wr(`TSG_ADDR_ADC_LEVEL, lvl);
			wr(`TSG_ADDR_CTRL, 32'h21 | (s << 4));
			@(posedge i_clk) i_sample <= 12'(lvl - sgn * 21);
			repeat (3) @(posedge i_clk);
			enter_state;
			@(posedge i_clk) i_sample <= 12'(lvl + sgn * 19);
			expect_start(1'b0, 6, "raw_hyst");
			@(posedge i_clk) i_sample <= 12'(lvl + sgn * 20);
			expect_start(1'b1, 6, "raw_edge");
			leave_state;
		end
		for (int k = 0; k < 4; k++) begin
			wr(`TSG_ADDR_CTRL, 32'h20 | (k[0] << 4) | (k[1] ? 5 : 2));
			@(posedge i_clk) {i_front_ecl, i_front_ttl} <= {2{k[0]}};
			repeat (4) @(posedge i_clk);
			enter_state;
			@(posedge i_clk) if (k[1]) i_front_ecl <= ~k[0]; else i_front_ttl <= ~k[0];
			expect_start(1'b0, 6, "front_other");
			@(posedge i_clk) if (k[1]) i_front_ttl <= ~k[0]; else i_front_ecl <= ~k[0];
			expect_start(1'b1, 6, "front_edge");
			leave_state;
		end
		wr(`TSG_ADDR_DWELL, 32'h3);
		wr(`TSG_ADDR_CTRL, 32'h23);
		enter_state;
		expect_start(1'b0, 8, "env_no_low");
		@(posedge i_clk) i_band_mag <= 24'h000001;
		repeat (2) @(posedge i_clk);
		@(posedge i_clk) i_band_mag <= 24'hFFFFFF;
		expect_start(1'b0, 8, "env_short_low");
		@(posedge i_clk) i_band_mag <= 24'h000001;
		repeat (8) @(posedge i_clk);
		@(posedge i_clk) i_band_mag <= 24'hFFFFFF;
		expect_start(1'b1, 8, "env_fire");
		leave_state;
		wr(`TSG_ADDR_CTRL, 32'h20);
		enter_state;
		@(posedge i_clk) i_front_ecl <= ~i_front_ecl;
		expect_start(1'b0, 6, "user_quiet");
		@(posedge i_clk) peer_pull <= 1'b1;
		expect_start(1'b1, 6, "user_pulled");
		chk("user_pull", 32'h0, {31'h0, o_sync_oe});
		@(posedge i_clk) peer_pull <= 1'b0;
		leave_state;
		finish_test;
	end
endmodule
